//--- hw/meter_page_consts.vh
// Offsets, field positions, reset values and timing counts of the metering register page
`ifndef METER_PAGE_CONSTS_VH
`define METER_PAGE_CONSTS_VH
`define ADDR_SECOND_CONFIGURATION      6'h00
`define ADDR_REGISTER_CHECKSUM         6'h01
`define ADDR_INSTANTANEOUS_CURRENT     6'h02
`define ADDR_INSTANTANEOUS_VOLTAGE     6'h03
`define ADDR_INSTANTANEOUS_POWER       6'h04
`define ADDR_ACTIVE_POWER_AVERAGE      6'h05
`define ADDR_CURRENT_RMS               6'h06
`define ADDR_VOLTAGE_RMS               6'h07
`define ADDR_REACTIVE_POWER_AVERAGE    6'h0E
`define ADDR_INSTANT_REACTIVE_POWER    6'h0F
`define ADDR_APPARENT_POWER            6'h14
`define ADDR_POWER_FACTOR              6'h15
`define ADDR_TEMPERATURE_VALUE         6'h1B
`define ADDR_TOTAL_ACTIVE_POWER        6'h1D
`define ADDR_TOTAL_APPARENT_POWER      6'h1E
`define ADDR_TOTAL_REACTIVE_POWER      6'h1F
`define ADDR_CURRENT_DC_OFFSET         6'h20
`define ADDR_CURRENT_GAIN              6'h21
`define ADDR_VOLTAGE_DC_OFFSET         6'h22
`define ADDR_VOLTAGE_GAIN              6'h23
`define ADDR_INSTANT_POWER_OFFSET      6'h24
`define ADDR_CURRENT_AC_OFFSET         6'h25
`define ADDR_LINE_TO_SAMPLE_RATIO      6'h31
`define ADDR_AVERAGING_SAMPLE_TOTAL    6'h33
`define ADDR_THERMAL_GAIN              6'h36
`define ADDR_THERMAL_OFFSET            6'h37
`define ADDR_FILTER_SETTLING_TIME      6'h39
`define ADDR_NO_LOAD_THRESHOLD         6'h3A
`define ADDR_OVERALL_GAIN              6'h3C
`define ADDR_ELAPSED_SAMPLE_TIME       6'h3D
// Extra registers outside the 64-location page
`define ADDR_HOST_LOCK                 7'h40
`define ADDR_DSP_LOCK                  7'h41
`define ADDR_LINE_CYCLE_TOTAL          7'h42
`define ADDR_STATUS                    7'h43
`define RST_SECOND_CONFIGURATION       24'h100200
`define RST_CURRENT_GAIN               24'h400000
`define RST_VOLTAGE_GAIN               24'h400000
`define RST_LINE_TO_SAMPLE_RATIO       24'h01999A
`define RST_AVERAGING_SAMPLE_TOTAL     24'h000FA0
`define RST_THERMAL_GAIN               24'h06B716
`define RST_THERMAL_OFFSET             24'hD53998
`define RST_FILTER_SETTLING_TIME       24'h00001E
`define RST_OVERALL_GAIN               24'h500000
`define RST_LINE_CYCLE_TOTAL           24'h000064
`define RST_ZERO24                     24'h000000
`define AVG_SELECT_BIT                 5
`define STATUS_SETTLED_BIT             0
`define STATUS_AVERAGING_SELECT_BIT_BIT            1
// Bit of each protectable location in the two lock masks
`define LOCK_SLOT_CONFIG               5'd0
`define LOCK_SLOT_CAL_BASE             5'd1
`define LOCK_SLOT_SAMPLE_TOTAL         5'd7
`define LOCK_SLOT_THERMAL_GAIN         5'd8
`define LOCK_SLOT_THERMAL_OFFSET       5'd9
`define LOCK_SLOT_SETTLING_TIME        5'd10
`define LOCK_SLOT_NO_LOAD              5'd11
`define LOCK_SLOT_OVERALL_GAIN         5'd12
`define LOCK_SLOT_NONE                 5'd31
`endif

//--- hw/meter_page.v
// Metering register page with APB slave, checksum and write protection
//
// What this block does
// - Every starred register is summed into the register checksum.
// - Averaging select bit five set chooses line-cycle averaging over sample count.
// - Checksum covers line-cycle total when averaging bit set, else sample total.
// - Each eligible register may be locked against host; all but sample total and overall gain also against processor.
// - A six-bit address field selects one of 64 page locations.
// - Line-to-sample ratio register resets to its default ratio.
// - Elapsed sample time counts sample periods from zero after reset.
// - Filters wait the settling register's sample periods after conversion start.
`timescale 1ns/1ns
`default_nettype none
`include "meter_page_consts.vh"
module meter_page #(
  parameter integer DATA_W = 24
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [31:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // Signal-processor side
  input  wire        sample_tick_in,
  input  wire        conv_start_in,
  input  wire        dsp_we_in,
  input  wire [5:0]  dsp_addr_in,
  input  wire [23:0] dsp_wdata_in,
  output reg         line_cycle_mode_out,
  output reg         filters_settled_out
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  reg [23:0] page_q [0:63];
  reg [23:0] host_lock_q;
  reg [23:0] dsp_lock_q;
  reg [23:0] line_cycle_total_q;
  reg [23:0] settle_cnt_q;
  reg        settling_q;
  reg        settled_q;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // Published locations of the page
  function is_published;
    input [5:0] a;
    begin
      if (a <= `ADDR_VOLTAGE_RMS) begin
        is_published = 1'b1;
      end else if (a == `ADDR_REACTIVE_POWER_AVERAGE) begin
        is_published = 1'b1;
      end else if (a == `ADDR_INSTANT_REACTIVE_POWER) begin
        is_published = 1'b1;
      end else if (a == `ADDR_APPARENT_POWER) begin
        is_published = 1'b1;
      end else if (a == `ADDR_POWER_FACTOR) begin
        is_published = 1'b1;
      end else if (a == `ADDR_TEMPERATURE_VALUE) begin
        is_published = 1'b1;
      end else if (a >= `ADDR_TOTAL_ACTIVE_POWER && a <= `ADDR_CURRENT_AC_OFFSET) begin
        is_published = 1'b1;
      end else if (a == `ADDR_LINE_TO_SAMPLE_RATIO) begin
        is_published = 1'b1;
      end else if (a == `ADDR_AVERAGING_SAMPLE_TOTAL) begin
        is_published = 1'b1;
      end else if (a == `ADDR_THERMAL_GAIN || a == `ADDR_THERMAL_OFFSET) begin
        is_published = 1'b1;
      end else if (a == `ADDR_FILTER_SETTLING_TIME || a == `ADDR_NO_LOAD_THRESHOLD) begin
        is_published = 1'b1;
      end else if (a == `ADDR_OVERALL_GAIN || a == `ADDR_ELAPSED_SAMPLE_TIME) begin
        is_published = 1'b1;
      end else begin
        is_published = 1'b0;
      end
    end
  endfunction

  function host_writable;
    input [5:0] a;
    begin
      if (a == `ADDR_SECOND_CONFIGURATION) begin
        host_writable = 1'b1;
      end else if (a >= `ADDR_CURRENT_DC_OFFSET && a <= `ADDR_CURRENT_AC_OFFSET) begin
        host_writable = 1'b1;
      end else if (a == `ADDR_AVERAGING_SAMPLE_TOTAL) begin
        host_writable = 1'b1;
      end else if (a == `ADDR_THERMAL_GAIN || a == `ADDR_THERMAL_OFFSET) begin
        host_writable = 1'b1;
      end else if (a == `ADDR_FILTER_SETTLING_TIME || a == `ADDR_NO_LOAD_THRESHOLD) begin
        host_writable = 1'b1;
      end else if (a == `ADDR_OVERALL_GAIN) begin
        host_writable = 1'b1;
      end else begin
        host_writable = 1'b0;
      end
    end
  endfunction

  // Locations summed into the checksum
  function in_checksum;
    input [5:0] a;
    begin
      if (a == `ADDR_SECOND_CONFIGURATION) begin
        in_checksum = 1'b1;
      end else if (a >= `ADDR_CURRENT_DC_OFFSET && a <= `ADDR_CURRENT_AC_OFFSET) begin
        in_checksum = 1'b1;
      end else if (a == `ADDR_THERMAL_GAIN || a == `ADDR_THERMAL_OFFSET) begin
        in_checksum = 1'b1;
      end else if (a == `ADDR_NO_LOAD_THRESHOLD || a == `ADDR_OVERALL_GAIN) begin
        in_checksum = 1'b1;
      end else begin
        in_checksum = 1'b0;
      end
    end
  endfunction

  function [23:0] reset_value;
    input integer a;
    begin
      if (a == `ADDR_SECOND_CONFIGURATION) begin
        reset_value = `RST_SECOND_CONFIGURATION;
      end else if (a == `ADDR_CURRENT_GAIN) begin
        reset_value = `RST_CURRENT_GAIN;
      end else if (a == `ADDR_VOLTAGE_GAIN) begin
        reset_value = `RST_VOLTAGE_GAIN;
      end else if (a == `ADDR_LINE_TO_SAMPLE_RATIO) begin
        reset_value = `RST_LINE_TO_SAMPLE_RATIO;
      end else if (a == `ADDR_AVERAGING_SAMPLE_TOTAL) begin
        reset_value = `RST_AVERAGING_SAMPLE_TOTAL;
      end else if (a == `ADDR_THERMAL_GAIN) begin
        reset_value = `RST_THERMAL_GAIN;
      end else if (a == `ADDR_THERMAL_OFFSET) begin
        reset_value = `RST_THERMAL_OFFSET;
      end else if (a == `ADDR_FILTER_SETTLING_TIME) begin
        reset_value = `RST_FILTER_SETTLING_TIME;
      end else if (a == `ADDR_OVERALL_GAIN) begin
        reset_value = `RST_OVERALL_GAIN;
      end else begin
        reset_value = `RST_ZERO24;
      end
    end
  endfunction

  // Word indexes that answer without an error
  function bus_mapped;
    input [6:0] w;
    begin
      if (w[6] == 1'b0) begin
        bus_mapped = is_published(w[5:0]);
      end else if (w == `ADDR_HOST_LOCK || w == `ADDR_DSP_LOCK) begin
        bus_mapped = 1'b1;
      end else if (w == `ADDR_LINE_CYCLE_TOTAL || w == `ADDR_STATUS) begin
        bus_mapped = 1'b1;
      end else begin
        bus_mapped = 1'b0;
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // Write protection
  // ------------------------------------------------------------------
  // Lock-mask bit of a protectable location, none for the others
  function [4:0] lock_slot;
    input [5:0] a;
    begin
      if (a == `ADDR_SECOND_CONFIGURATION) begin
        lock_slot = `LOCK_SLOT_CONFIG;
      end else if (a >= `ADDR_CURRENT_DC_OFFSET && a <= `ADDR_CURRENT_AC_OFFSET) begin
        lock_slot = {2'b00, a[2:0]} + `LOCK_SLOT_CAL_BASE;
      end else if (a == `ADDR_AVERAGING_SAMPLE_TOTAL) begin
        lock_slot = `LOCK_SLOT_SAMPLE_TOTAL;
      end else if (a == `ADDR_THERMAL_GAIN) begin
        lock_slot = `LOCK_SLOT_THERMAL_GAIN;
      end else if (a == `ADDR_THERMAL_OFFSET) begin
        lock_slot = `LOCK_SLOT_THERMAL_OFFSET;
      end else if (a == `ADDR_FILTER_SETTLING_TIME) begin
        lock_slot = `LOCK_SLOT_SETTLING_TIME;
      end else if (a == `ADDR_NO_LOAD_THRESHOLD) begin
        lock_slot = `LOCK_SLOT_NO_LOAD;
      end else if (a == `ADDR_OVERALL_GAIN) begin
        lock_slot = `LOCK_SLOT_OVERALL_GAIN;
      end else begin
        lock_slot = `LOCK_SLOT_NONE;
      end
    end
  endfunction

  // Processor locks skip the host-only locations
  function dsp_lockable;
    input [4:0] s;
    begin
      if (s == `LOCK_SLOT_SAMPLE_TOTAL || s == `LOCK_SLOT_OVERALL_GAIN) begin
        dsp_lockable = 1'b0;
      end else begin
        dsp_lockable = s != `LOCK_SLOT_NONE;
      end
    end
  endfunction

  // One mask bit per protectable location
  function is_locked;
    input [23:0] mask;
    input [4:0]  s;
    begin
      if (s < 5'd24) begin
        is_locked = mask[s];
      end else begin
        is_locked = 1'b0;
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire        setup_rd  = psel_in && !penable_in && !pwrite_in;
  wire        access_wr = psel_in && penable_in && pwrite_in && pready_out;
  wire        word_ok   = paddr_in[1:0] == 2'b00 && paddr_in[31:9] == 23'h000000;
  wire [6:0]  widx      = paddr_in[8:2];
  wire [5:0]  ra        = widx[5:0];
  wire        in_page   = word_ok && !widx[6];
  wire        full_strb = pstrb_in[2:0] == 3'b111;
  wire [23:0] wdat      = pwdata_in[23:0];

  // Host page write: published, writable, unlocked
  wire [4:0] host_slot = lock_slot(ra);
  wire [4:0] dsp_slot  = lock_slot(dsp_addr_in);
  wire host_pg_we = access_wr && in_page && host_writable(ra) && full_strb &&
                    !is_locked(host_lock_q, host_slot);
  wire host_hl_we = access_wr && word_ok && widx == `ADDR_HOST_LOCK && full_strb;
  wire host_dl_we = access_wr && word_ok && widx == `ADDR_DSP_LOCK && full_strb;
  wire host_cc_we = access_wr && word_ok && widx == `ADDR_LINE_CYCLE_TOTAL && full_strb;
  wire dsp_lock_hit = dsp_lockable(dsp_slot) && is_locked(dsp_lock_q, dsp_slot);
  wire dsp_pg_we  = dsp_we_in && is_published(dsp_addr_in) && !dsp_lock_hit;

  wire avg_sel = page_q[`ADDR_SECOND_CONFIGURATION][`AVG_SELECT_BIT];

  // ------------------------------------------------------------------
  // Checksum: sum of covered locations
  // ------------------------------------------------------------------
  reg [23:0] csum_d;
  integer k;
  always @* begin
    csum_d = 24'h000000;
    for (k = 0; k < 64; k = k + 1) begin
      if (in_checksum(k[5:0])) begin
        csum_d = csum_d + page_q[k];
      end
    end
    if (avg_sel) begin
      csum_d = csum_d + line_cycle_total_q;
    end else begin
      csum_d = csum_d + page_q[`ADDR_AVERAGING_SAMPLE_TOTAL];
    end
  end

  // ------------------------------------------------------------------
  // Page storage
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_page
      always @(posedge clk_in) begin
        if (!rst_n_in) begin
          page_q[g] <= reset_value(g);
        end else if (g == `ADDR_REGISTER_CHECKSUM) begin
          page_q[g] <= csum_d;
        end else if (g == `ADDR_ELAPSED_SAMPLE_TIME) begin
          if (sample_tick_in) begin
            page_q[g] <= page_q[g] + 24'h000001;
          end
        end else if (host_pg_we && ra == g) begin
          page_q[g] <= wdat;
        end else if (dsp_pg_we && dsp_addr_in == g) begin
          page_q[g] <= dsp_wdata_in;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Locks, line-cycle total, settling
  // ------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      host_lock_q        <= 24'h000000;
      dsp_lock_q         <= 24'h000000;
      line_cycle_total_q <= `RST_LINE_CYCLE_TOTAL;
    end else begin
      if (host_hl_we) begin
        host_lock_q <= wdat;
      end
      if (host_dl_we) begin
        dsp_lock_q <= wdat;
      end
      if (host_cc_we) begin
        line_cycle_total_q <= wdat;
      end
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      settle_cnt_q <= 24'h000000;
      settling_q   <= 1'b0;
      settled_q    <= 1'b0;
    end else if (conv_start_in) begin
      settle_cnt_q <= 24'h000000;
      settling_q   <= 1'b1;
      settled_q    <= 1'b0;
    end else if (settling_q && sample_tick_in) begin
      if (settle_cnt_q + 24'h000001 >= page_q[`ADDR_FILTER_SETTLING_TIME]) begin
        settling_q <= 1'b0;
        settled_q  <= 1'b1;
      end
      settle_cnt_q <= settle_cnt_q + 24'h000001;
    end
  end

  // ------------------------------------------------------------------
  // APB answer: one wait-free access phase, read data latched at setup
  // ------------------------------------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    if (!word_ok) begin
      rd_d = 32'h00000000;
    end else if (in_page) begin
      if (is_published(ra)) begin
        rd_d = {8'h00, page_q[ra]};
      end
    end else if (widx == `ADDR_HOST_LOCK) begin
      rd_d = {8'h00, host_lock_q[23:0]};
    end else if (widx == `ADDR_DSP_LOCK) begin
      rd_d = {8'h00, dsp_lock_q[23:0]};
    end else if (widx == `ADDR_LINE_CYCLE_TOTAL) begin
      rd_d = {8'h00, line_cycle_total_q};
    end else if (widx == `ADDR_STATUS) begin
      rd_d = {30'h00000000, avg_sel, settled_q};
    end
  end

  wire mapped = word_ok && bus_mapped(widx);

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_out          <= 32'h00000000;
      pready_out          <= 1'b0;
      pslverr_out         <= 1'b0;
      line_cycle_mode_out <= 1'b0;
      filters_settled_out <= 1'b0;
    end else begin
      line_cycle_mode_out <= avg_sel;
      filters_settled_out <= settled_q;
      pready_out          <= psel_in && !penable_in;
      pslverr_out         <= psel_in && !penable_in && !mapped;
      if (setup_rd) begin
        prdata_out <= rd_d;
      end
    end
  end

endmodule // meter_page
`default_nettype wire

//--- tb/meter_page_checker.sv
// Port-level assertions for the metering register page
`timescale 1ns/1ns
`default_nettype none
module meter_page_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        conv_start_in,
  input wire logic        filters_settled_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  sequence answer_s;
    pready_out ##1 !pready_out;
  endsequence
  chk_zero_wait: assert property (setup_s |=> answer_s)
    else $error("answer not in the access cycle");
  chk_idle_quiet: assert property (!psel_in |=> !pready_out)
    else $error("ready without a request");
  chk_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  chk_reserved_err: assert property (setup_s and paddr_in == 32'h00000020
    |=> pready_out && pslverr_out) else $error("reserved access not flagged");
  chk_mapped_ok: assert property (setup_s and paddr_in == 32'h000000E4
    |=> pready_out && !pslverr_out) else $error("mapped access flagged");
  chk_ratio_fixed: assert property (pready_out && !pwrite_in
    && paddr_in == 32'h000000C4 |-> prdata_out == 32'h0001999A) else $error("ratio changed");
  chk_upper_zero: assert property (pready_out |-> prdata_out[31:24] == 8'h00)
    else $error("read data upper byte set");
  chk_settle_drop: assert property (conv_start_in |-> ##2 !filters_settled_out)
    else $error("settled right after start");
endmodule // meter_page_checker
bind meter_page meter_page_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .conv_start_in(conv_start_in), .filters_settled_out(filters_settled_out));
`default_nettype wire

//--- tb/apb_host.sv
// Behavioural APB host issuing one transfer per request
`timescale 1ns/1ns
`default_nettype none
module apb_host (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wd_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [31:0]      paddr_out,
  output logic [31:0]      pwdata_out,
  output logic             done_out,
  output logic             err_out,
  output logic [31:0]      rd_out
);
  initial begin
    {psel_out, penable_out, pwrite_out, done_out, err_out} = 5'h00;
    {paddr_out, pwdata_out, rd_out} = 96'h0;
  end
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (!psel_out && go_in) begin
      psel_out <= 1'b1;
      pwrite_out <= wr_in;
      paddr_out <= addr_in;
      pwdata_out <= wd_in;
    end else if (psel_out && !penable_out) begin
      penable_out <= 1'b1;
    end else if (penable_out && pready_in) begin
      {psel_out, penable_out, done_out} <= 3'h1;
      rd_out <= prdata_in;
      err_out <= pslverr_in;
      // Released bus shows no stale value
      paddr_out <= ~paddr_out;
      pwdata_out <= ~pwdata_out;
    end
  end
endmodule // apb_host
`default_nettype wire

//--- tb/meter_page_tb.sv
// Self-checking bench for the metering register page
`timescale 1ns/1ns
`default_nettype none
`include "meter_page_consts.vh"
module meter_page_tb;
  logic        clk_in = 0, rst_n_in = 0, go = 0, wr = 0, tick = 0, cst = 0, dwe = 0;
  logic        done, err, psel, pen, pwr, pready, pslverr, lcm, settled;
  logic [31:0] addr = 0, wd = 0, rd, paddr, pwdata, prdata, seed = 32'h5F91A00C;
  logic [5:0]  da = 0;
  logic [23:0] dd = 0, d;
  logic [23:0] sh [0:127];
  logic [6:0]  x;
  integer      err_count = 0, n_checks = 0, i, ticks = 0;
  localparam logic [6:0] rw_list [12] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
    7'h33, 7'h36, 7'h37, 7'h3A, 7'h3C, 7'h42};
  always #4 clk_in = ~clk_in;
  apb_host host (.clk_in(clk_in), .go_in(go), .wr_in(wr), .addr_in(addr), .wd_in(wd),
    .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata), .psel_out(psel),
    .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr), .pwdata_out(pwdata),
    .done_out(done), .err_out(err), .rd_out(rd));
  meter_page dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .sample_tick_in(tick), .conv_start_in(cst), .dsp_we_in(dwe), .dsp_addr_in(da),
    .dsp_wdata_in(dd), .line_cycle_mode_out(lcm), .filters_settled_out(settled));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic mapped(input logic [6:0] a);
    return a inside {[7'h00:7'h07], 7'h0E, 7'h0F, 7'h14, 7'h15, 7'h1B, [7'h1D:7'h25],
      7'h31, 7'h33, 7'h36, 7'h37, 7'h39, 7'h3A, 7'h3C, 7'h3D};
  endfunction
  function logic [23:0] exp_of(input logic [6:0] a);
    integer j;
    exp_of = sh[a];
    if (a == 7'h3D) exp_of = ticks[23:0];
    if (a == 7'h01) begin
      exp_of = sh[0] + sh[7'h36] + sh[7'h37] + sh[7'h3A] + sh[7'h3C];
      exp_of += sh[0][`AVG_SELECT_BIT] ? sh[7'h42] : sh[7'h33];
      for (j = 32; j < 38; j++) exp_of += sh[j];
    end
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("mismatches=%0d checks=%0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task bus(input logic w, input logic [6:0] a, input logic [23:0] v);
    integer k;
    @(posedge clk_in);
    {go, wr, addr, wd} <= {1'b1, w, 23'h0, a, 2'h0, 8'h00, v};
    @(posedge clk_in);
    go <= 1'b0;
    for (k = 0; k < 16 && done !== 1'b1; k++) @(posedge clk_in);
    if (done !== 1'b1) begin
      err_count++;
      summarize;
    end
  endtask
  task rchk(input logic [6:0] a);
    bus(1'b0, a, 24'h000000);
    check(rd, {8'h00, exp_of(a)});
  endtask
  task dsp(input logic [5:0] a, input logic [23:0] v);
    @(posedge clk_in);
    {dwe, da, dd} <= {1'b1, a, v};
    @(posedge clk_in);
    dwe <= 1'b0;
  endtask
  task tick_p;
    @(posedge clk_in) tick <= 1'b1;
    @(posedge clk_in) tick <= 1'b0;
    ticks++;
  endtask
  initial begin
    for (i = 0; i < 128; i++) sh[i] = `RST_ZERO24;
    sh[0] = `RST_SECOND_CONFIGURATION;
    sh[7'h21] = `RST_CURRENT_GAIN;
    sh[7'h23] = `RST_VOLTAGE_GAIN;
    sh[7'h31] = 24'h01999A;
    sh[7'h33] = 24'h000FA0;
    sh[7'h36] = 24'h06B716;
    sh[7'h37] = 24'hD53998;
    sh[7'h39] = 24'h00001E;
    sh[7'h3C] = 24'h500000;
    sh[7'h42] = `RST_LINE_CYCLE_TOTAL;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 64; i++) begin
      x = i[6:0];
      bus(1'b0, x, 24'h000000);
      check({31'h0, err}, {31'h0, ~mapped(x)});
      if (mapped(x)) check(rd, {8'h00, exp_of(x)});
    end
    for (i = 0; i < 16; i++) begin
      x = rw_list[rnd() % 12];
      d = 24'(rnd());
      bus(1'b1, x, d);
      sh[x] = d;
      rchk(x);
      rchk(7'h01);
    end
    bus(1'b1, 7'h31, 24'h000000);
    rchk(7'h31);
    bus(1'b1, 7'h08, 24'(rnd()));
    check({31'h0, err}, 32'h1);
    sh[0] = 24'h100220;
    bus(1'b1, 7'h00, sh[0]);
    repeat (2) @(posedge clk_in);
    check({31'h0, lcm}, 32'h1);
    rchk(7'h01);
    bus(1'b1, 7'h40, 24'h000001);
    bus(1'b1, 7'h00, 24'h000000);
    rchk(7'h00);
    sh[0] = `RST_SECOND_CONFIGURATION;
    dsp(6'h00, sh[0]);
    rchk(7'h00);
    bus(1'b1, 7'h41, 24'h000001);
    dsp(6'h00, 24'h000000);
    rchk(7'h00);
    bus(1'b1, 7'h40, 24'h001000);
    bus(1'b1, 7'h3C, 24'h0ABCDE);
    rchk(7'h3C);
    bus(1'b1, 7'h41, 24'h000100);
    dsp(6'h36, 24'h000000);
    rchk(7'h36);
    sh[7'h39] = 24'h000003;
    bus(1'b1, 7'h39, sh[7'h39]);
    @(posedge clk_in) cst <= 1'b1;
    @(posedge clk_in) cst <= 1'b0;
    repeat (2) tick_p;
    check({31'h0, settled}, 32'h0);
    tick_p;
    repeat (3) @(posedge clk_in);
    check({31'h0, settled}, 32'h1);
    bus(1'b0, 7'h43, 24'h000000);
    check(rd, {30'h0, sh[0][`AVG_SELECT_BIT], 1'b1});
    @(posedge clk_in) cst <= 1'b1;
    @(posedge clk_in) cst <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({31'h0, settled}, 32'h0);
    rchk(7'h3D);
    summarize;
  end
endmodule // meter_page_tb
`default_nettype wire
